// ===== hw/tmr_chan.sv
// One channel of the multimode 16-bit timer group with its Avalon-MM register slave
//
// Functional notes
// - Timer mode counts internal ticks down, reloads on underflow, requests interrupt.
// - Counting happens only while the run flag is 1.
// - Count write: stopped loads counter and reload, running only reload; read is live.
// - Timer gate: input pin level starts and stops counting.
// - Pulse output toggles on underflow, low when stopped, high when inverted.
// - Event source: pin edge, second-group timer 2, previous or next channel.
// - Event direction by software; overflow or underflow requests interrupt.
// - Free-run wraps on overflow or underflow without reloading.
// - Two-phase on channels 2-4; 2 normal, 4 multiply-by-4, 3 selectable.
// - Normal two-phase: output pin high, input rise up, input fall down.
// - Multiply-by-4 counts every edge of both pins with quadrature direction.
// - Z-phase clear only on channel 3, two-phase, free-run, multiply-by-4.
// - Z-phase edge sense follows the edge sense select flag.
// - After a Z edge the count clears to 0 at the next count timing.
// - Z clear coinciding with over/underflow gives two interrupt requests back to back.
// - One-shot counts down, at zero requests interrupt, reloads, stops; trigger restarts.
// - One-shot lasts setting ticks; a setting of 0000h stays idle.
// - One-shot starts on run and a trigger: pin, timers, or start flag.
// - One-shot write loads counter until first tick after start, then reload only.
// - One-shot pulse output high while counting, low otherwise, invertible.
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module tmr_chan #(
  parameter int CHANNEL = 0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [tmr_chan_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Count sources, same clock domain, one-cycle pulses
  input wire logic count_tick,
  input wire logic b2_event,
  input wire logic prev_event,
  input wire logic next_event,
  // Pins
  input wire logic channel_input_pin,
  input wire logic channel_output_pin_i,
  output logic channel_output_pin_o,
  output logic channel_output_pin_oe_n,
  input wire logic zphase_input_pin,
  // Events
  output logic wrap_event,
  output logic irq_req
);
  import tmr_chan_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] reload;
    logic [MD_W-1:0] mode_reg;
    logic run;
    logic zen;
    logic zsense;
    logic tog;
    logic active;
    logic first_seen;
    logic zpend;
    logic out;
    logic wrap;
    logic irq;
    logic irq2;
    logic in_s1;
    logic in_s2;
    logic in_d;
    logic op_s1;
    logic op_s2;
    logic op_d;
    logic z_s1;
    logic z_s2;
    logic z_d;
  } state_t;

  localparam state_t ST_RESET = '{
    ack: 1'b0, rdata: 32'h0000_0000, cnt: CNT_RESET, reload: CNT_RESET,
    mode_reg: MODE_RESET, default: 1'b0};

  if (CHANNEL < 0 || CHANNEL > 4) begin : g_bad_channel
    $error("CHANNEL must be 0 to 4");
  end

  function automatic logic edge_hit(input logic rise, input logic fall, input edge_t sel);
    edge_hit = (rise && sel[0]) || (fall && (sel == EDGE_FALL || sel == EDGE_BOTH));
  endfunction

  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] be);
    merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
  endfunction

  state_t st_ff;
  state_t nxt_st;

  mode_t mode;
  src_t src;
  logic in_rise, in_fall, op_rise, op_fall, z_rise, z_fall;
  logic two_ph, mul4_eff, zclr_ok;
  logic ev_hit, ev_up, q_up;
  logic gate_ok, trigger, os_start_wr, cnt_wr, wrap_now, boundary;
  logic [CNT_W-1:0] wr_val;

  assign mode = mode_t'(st_ff.mode_reg[MD_MODE_LSB +: 2]);
  assign src = src_t'(st_ff.mode_reg[MD_SRC_LSB +: 2]);
  assign in_rise = st_ff.in_s2 && !st_ff.in_d;
  assign in_fall = !st_ff.in_s2 && st_ff.in_d;
  assign op_rise = st_ff.op_s2 && !st_ff.op_d;
  assign op_fall = !st_ff.op_s2 && st_ff.op_d;
  assign z_rise = st_ff.z_s2 && !st_ff.z_d;
  assign z_fall = !st_ff.z_s2 && st_ff.z_d;

  // Two-phase exists on channels 2 to 4; processing kind is fixed except on 3
  assign two_ph = (CHANNEL >= 2) && st_ff.mode_reg[MD_TWO_PH] && (mode == MODE_EVENT);
  assign mul4_eff = (CHANNEL == 4) || ((CHANNEL == 3) && st_ff.mode_reg[MD_MUL4]);
  assign zclr_ok = (CHANNEL == 3) && two_ph && mul4_eff && st_ff.mode_reg[MD_FREE]
                   && st_ff.zen;
  assign q_up = mul4_eff ? (st_ff.in_s2 ~^ st_ff.op_d) : in_rise;

  always_comb begin
    ev_hit = 1'b0;
    ev_up = st_ff.mode_reg[MD_UP];
    if (two_ph) begin
      if (mul4_eff) begin
        ev_hit = (in_rise || in_fall) ^ (op_rise || op_fall);
      end else begin
        ev_hit = st_ff.op_s2 && (in_rise || in_fall);
      end
      ev_up = q_up;
    end else begin
      case (src)
        SRC_PIN: ev_hit = edge_hit(in_rise, in_fall,
                                   edge_t'(st_ff.mode_reg[MD_EDGE_LSB +: 2]));
        SRC_B2: ev_hit = b2_event;
        SRC_PREV: ev_hit = prev_event;
        SRC_NEXT: ev_hit = next_event;
        default: ev_hit = 1'b0;
      endcase
    end
  end

  assign gate_ok = !st_ff.mode_reg[MD_GATE_EN]
                   || (st_ff.in_s2 == st_ff.mode_reg[MD_GATE_LVL]);
  assign os_start_wr = write && st_ff.ack && (address == OFS_CTRL) && byteenable[0]
                       && writedata[CT_OS_START];
  assign trigger = ev_hit || os_start_wr;
  assign cnt_wr = write && st_ff.ack && (address == OFS_COUNT);
  assign wr_val = merge16(st_ff.reload, writedata, byteenable);
  assign boundary = ev_up ? (st_ff.cnt == CNT_MAX) : (st_ff.cnt == CNT_RESET);

  always_comb begin
    nxt_st = st_ff;
    wrap_now = 1'b0;
    nxt_st.wrap = 1'b0;
    // A pending second request goes out the cycle after the first
    nxt_st.irq = st_ff.irq2;
    nxt_st.irq2 = 1'b0;
    nxt_st.in_s1 = channel_input_pin;
    nxt_st.in_s2 = st_ff.in_s1;
    nxt_st.in_d = st_ff.in_s2;
    nxt_st.op_s1 = channel_output_pin_i;
    nxt_st.op_s2 = st_ff.op_s1;
    nxt_st.op_d = st_ff.op_s2;
    nxt_st.z_s1 = zphase_input_pin;
    nxt_st.z_s2 = st_ff.z_s1;
    nxt_st.z_d = st_ff.z_s2;

    // Bus: one wait cycle, then the request is taken
    nxt_st.ack = (read || write) && !st_ff.ack;
    if (read && !st_ff.ack) begin
      case (address)
        OFS_COUNT: nxt_st.rdata = {16'h0000, st_ff.cnt};
        OFS_MODE: nxt_st.rdata = {18'h00000, st_ff.mode_reg};
        OFS_CTRL: nxt_st.rdata = {28'h0000000, st_ff.zsense, st_ff.zen, 1'b0, st_ff.run};
        OFS_STAT: nxt_st.rdata = {29'h00000000, st_ff.zpend, st_ff.out, st_ff.active};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    case (mode)
      MODE_TIMER: begin
        if (st_ff.run && count_tick && gate_ok) begin
          if (st_ff.cnt == CNT_RESET) begin
            nxt_st.cnt = st_ff.reload;
            wrap_now = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
          end
        end
      end
      MODE_EVENT: begin
        if (st_ff.run && ev_hit) begin
          if (st_ff.zpend) begin
            // Clear takes this count timing; a coincident wrap asks twice
            nxt_st.cnt = CNT_RESET;
            nxt_st.irq2 = boundary;
            wrap_now = boundary;
          end else if (boundary) begin
            wrap_now = 1'b1;
            if (st_ff.mode_reg[MD_FREE]) begin
              nxt_st.cnt = ev_up ? CNT_RESET : CNT_MAX;
            end else begin
              nxt_st.cnt = st_ff.reload;
            end
          end else begin
            nxt_st.cnt = ev_up ? st_ff.cnt + 16'h0001 : st_ff.cnt - 16'h0001;
          end
        end
      end
      MODE_ONESHOT: begin
        if (st_ff.run && trigger && st_ff.reload != CNT_RESET) begin
          // A trigger while counting restarts from the reload value
          nxt_st.active = 1'b1;
          nxt_st.first_seen = 1'b0;
          nxt_st.cnt = st_ff.reload;
        end else if (st_ff.run && st_ff.active && count_tick) begin
          nxt_st.first_seen = 1'b1;
          if (st_ff.cnt <= 16'h0001) begin
            nxt_st.cnt = st_ff.reload;
            nxt_st.active = 1'b0;
            wrap_now = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
          end
        end
      end
      default: begin
      end
    endcase

    if (wrap_now) begin
      nxt_st.irq = 1'b1;
      nxt_st.wrap = 1'b1;
      nxt_st.tog = !st_ff.tog;
    end

    // Z edge is remembered until the next count timing; a new edge wins over the clear
    if (st_ff.run && ev_hit && st_ff.zpend) begin
      nxt_st.zpend = 1'b0;
    end
    if (zclr_ok && (st_ff.zsense ? z_rise : z_fall)) begin
      nxt_st.zpend = 1'b1;
    end
    if (!zclr_ok) begin
      nxt_st.zpend = 1'b0;
    end

    if (cnt_wr) begin
      nxt_st.reload = wr_val;
      if (!st_ff.run || (mode == MODE_ONESHOT && !(st_ff.active && st_ff.first_seen))) begin
        nxt_st.cnt = wr_val;
      end
    end
    if (write && st_ff.ack && address == OFS_MODE) begin
      if (byteenable[0]) begin
        nxt_st.mode_reg[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
        nxt_st.mode_reg[MD_W-1:8] = writedata[MD_W-1:8];
      end
    end
    if (write && st_ff.ack && address == OFS_CTRL && byteenable[0]) begin
      nxt_st.run = writedata[CT_RUN];
      nxt_st.zen = writedata[CT_ZEN];
      nxt_st.zsense = writedata[CT_ZSENSE];
    end

    // Stopping kills the one-shot and parks the toggle low
    if (!nxt_st.run) begin
      nxt_st.active = 1'b0;
      nxt_st.tog = 1'b0;
    end
    if (nxt_st.mode_reg[MD_MODE_LSB +: 2] == MODE_ONESHOT) begin
      nxt_st.out = nxt_st.active ^ nxt_st.mode_reg[MD_INVERT];
    end else begin
      nxt_st.out = nxt_st.tog ^ nxt_st.mode_reg[MD_INVERT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign waitrequest = (read || write) && !st_ff.ack;
  assign readdata = st_ff.rdata;
  assign wrap_event = st_ff.wrap;
  assign irq_req = st_ff.irq;
  assign channel_output_pin_o = st_ff.out;
  // In two-phase mode the output pin is the second encoder input
  assign channel_output_pin_oe_n = !st_ff.mode_reg[MD_PULSE_EN] || two_ph;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_stop_holds_count: assert property (
    (!st_ff.run && !cnt_wr) |=> $stable(st_ff.cnt))
    else $error("count moved while stopped");
  a_timer_underflow: assert property (
    (mode == MODE_TIMER && st_ff.run && count_tick && gate_ok && st_ff.cnt == CNT_RESET
     && !cnt_wr) |=> (st_ff.cnt == $past(st_ff.reload)) && irq_req)
    else $error("timer underflow did not reload");
  a_gate_blocks: assert property (
    (mode == MODE_TIMER && !gate_ok && !cnt_wr) |=> $stable(st_ff.cnt))
    else $error("gate closed but count moved");
  a_write_running: assert property (
    (cnt_wr && st_ff.run && mode == MODE_TIMER && !count_tick)
    |=> $stable(st_ff.cnt) && st_ff.reload == $past(wr_val))
    else $error("running write reached the counter");
  a_out_parked: assert property (
    (!st_ff.run && mode != MODE_ONESHOT)[*2] |-> channel_output_pin_o
      == st_ff.mode_reg[MD_INVERT])
    else $error("stopped output level wrong");
  a_free_wrap: assert property (
    (mode == MODE_EVENT && st_ff.run && ev_hit && !ev_up && st_ff.mode_reg[MD_FREE]
     && st_ff.cnt == CNT_RESET && !st_ff.zpend && !cnt_wr) |=> st_ff.cnt == CNT_MAX)
    else $error("free run did not wrap");
  a_zphase_clear: assert property (
    (mode == MODE_EVENT && st_ff.run && ev_hit && st_ff.zpend && !cnt_wr)
    |=> st_ff.cnt == CNT_RESET)
    else $error("Z edge did not clear count");
  a_double_request: assert property (
    (st_ff.run && ev_hit && st_ff.zpend && boundary && mode == MODE_EVENT)
    |=> irq_req ##1 irq_req)
    else $error("coincident clear lost a request");
  a_oneshot_end: assert property (
    (mode == MODE_ONESHOT && st_ff.run && st_ff.active && count_tick && !trigger
     && st_ff.cnt <= 16'h0001) |=> !st_ff.active && irq_req)
    else $error("one-shot did not stop at zero");
  a_oneshot_idle: assert property (
    (mode == MODE_ONESHOT && !st_ff.active && st_ff.reload == CNT_RESET && !cnt_wr)
    |=> !st_ff.active)
    else $error("zero setting started the one-shot");
  a_oneshot_pin: assert property (
    (mode == MODE_ONESHOT && $stable(st_ff.mode_reg)) |=> channel_output_pin_o
      == (st_ff.active ^ st_ff.mode_reg[MD_INVERT]))
    else $error("one-shot output level wrong");
  a_bus_answer: assert property (
    ($rose(read || write)) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");

  c_timer_underflow: cover property (mode == MODE_TIMER && wrap_now);
  c_event_up_wrap: cover property (mode == MODE_EVENT && ev_up && wrap_now);
  c_zphase_clear: cover property (st_ff.zpend && ev_hit && st_ff.run);
  c_oneshot_retrigger: cover property (st_ff.active && trigger && st_ff.run);

endmodule

// ===== hw/tmr_chan_pkg.sv
// Register map, field layout and constants of the multimode timer channel
package tmr_chan_pkg;

  localparam int ADDR_W = 4;
  localparam int CNT_W = 16;

  // Byte offsets of the word registers
  localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'hc;

  // channel_mode_register fields
  localparam int MD_MODE_LSB = 0;
  localparam int MD_GATE_EN = 2;
  localparam int MD_GATE_LVL = 3;
  localparam int MD_PULSE_EN = 4;
  localparam int MD_INVERT = 5;
  localparam int MD_UP = 6;
  localparam int MD_FREE = 7;
  localparam int MD_TWO_PH = 8;
  localparam int MD_MUL4 = 9;
  localparam int MD_SRC_LSB = 10;
  localparam int MD_EDGE_LSB = 12;
  localparam int MD_W = 14;

  // count_start_register / one_shot_start_register / ext_int2_control_register bits
  localparam int CT_RUN = 0;
  localparam int CT_OS_START = 1;
  localparam int CT_ZEN = 2;
  localparam int CT_ZSENSE = 3;

  // Status bits
  localparam int ST_ACTIVE = 0;
  localparam int ST_OUT = 1;
  localparam int ST_ZPEND = 2;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [MD_W-1:0] MODE_RESET = 14'h0000;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_ONESHOT = 2'b11,
    MODE_RSVD = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_B2 = 2'b01,
    SRC_PREV = 2'b11,
    SRC_NEXT = 2'b10
  } src_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b11,
    EDGE_NONE = 2'b10
  } edge_t;

endpackage

// ===== sim/encoder_model.sv
// Quadrature encoder and Z-phase source driving the timer channel pins
`timescale 1ns/100ps
module encoder_model (
  // Clock that times every pin change
  input wire logic mclk,
  // Pins toward the channel
  output logic phase_a,
  output logic phase_b,
  output logic zphase
);
  logic [1:0] pos;

  initial begin
    pos = 2'h0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    zphase = 1'b0;
  end

  // Gray order of (a, b) is 00, 01, 11, 10: forward means a rises while b is high
  task automatic step(input logic up);
    @(posedge mclk);
    pos = up ? pos + 2'h1 : pos - 2'h1;
    phase_a <= pos[1];
    phase_b <= pos[1] ^ pos[0];
    // Long hold so the pin synchronisers never miss a level
    repeat (6) @(posedge mclk);
  endtask

  task automatic zpulse();
    @(posedge mclk);
    zphase <= 1'b1;
    repeat (6) @(posedge mclk);
    zphase <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ===== sim/multimode_timer_a_channel_bench.sv
// Self-checking bench for one multimode timer channel
`timescale 1ns/100ps
module multimode_timer_a_channel_bench;
  import tmr_chan_pkg::*;
  typedef struct {
    logic [31:0] mode;
    logic [31:0] ctrl;
    logic [15:0] load;
    int sel;
    int n;
    logic [15:0] cnt;
    int irq;
  } row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic count_tick = 1'b0;
  logic b2_event = 1'b0;
  logic prev_event = 1'b0;
  logic next_event = 1'b0;
  logic phase_a;
  logic phase_b;
  logic zphase;
  logic out_pin;
  logic oe_n;
  logic wrap_event;
  logic irq_req;
  logic [31:0] pins;
  logic [31:0] q;
  int failures = 0;
  int checks = 0;
  int irqs = 0;
  int wraps = 0;
  int base;
  int wbase;
  // mode, ctrl, load, source (0 tick, 1 b2, 2 prev, 3 next), pulses, count, irqs
  row_t rows[9] = '{
    '{32'h0, 32'h1, 16'h5, 0, 3, 16'h2, 0},
    '{32'h0, 32'h1, 16'h2, 0, 4, 16'h1, 1},
    '{32'h0, 32'h0, 16'h5, 0, 3, 16'h5, 0},
    '{32'hc, 32'h1, 16'h5, 0, 3, 16'h5, 0},
    '{32'h4, 32'h1, 16'h5, 0, 3, 16'h2, 0},
    '{32'h401, 32'h1, 16'ha, 1, 3, 16'h7, 0},
    '{32'hc41, 32'h1, 16'hfffe, 2, 3, 16'hffff, 1},
    '{32'h8c1, 32'h1, 16'hfffe, 3, 3, 16'h1, 1},
    '{32'h881, 32'h1, 16'h1, 3, 3, 16'hfffe, 1}
  };

  assign pins = {30'h0, oe_n, out_pin};

  always #25 mclk = ~mclk;

  always @(posedge mclk) begin
    if (irq_req === 1'b1) begin
      irqs <= irqs + 1;
    end
    if (wrap_event === 1'b1) begin
      wraps <= wraps + 1;
    end
  end

  tmr_chan #(.CHANNEL(3)) tmr_chan_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .count_tick(count_tick),
    .b2_event(b2_event),
    .prev_event(prev_event),
    .next_event(next_event),
    .channel_input_pin(phase_a),
    .channel_output_pin_i(phase_b),
    .channel_output_pin_o(out_pin),
    .channel_output_pin_oe_n(oe_n),
    .zphase_input_pin(zphase),
    .wrap_event(wrap_event),
    .irq_req(irq_req)
  );

  encoder_model encoder_model_i (
    .mclk(mclk),
    .phase_a(phase_a),
    .phase_b(phase_b),
    .zphase(zphase)
  );

  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20) begin
      failures++;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic pulse(input int s);
    @(posedge mclk);
    count_tick <= (s == 0);
    b2_event <= (s == 1);
    prev_event <= (s == 2);
    next_event <= (s == 3);
    @(posedge mclk);
    {count_tick, b2_event, prev_event, next_event} <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask

  initial begin
    // Sized well above the few hundred cycles the sequence needs
    repeat (30000) @(posedge mclk);
    failures++;
    results();
  end

  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h0);
    bus(1'b0, OFS_MODE, 32'h0, q);
    check(q, {18'h0, MODE_RESET});
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    check(pins, 32'h2);
    // Low lane write merges into the upper byte already held
    bus(1'b1, OFS_COUNT, 32'h1234, q);
    byteenable <= 4'h1;
    bus(1'b1, OFS_COUNT, 32'h56ab, q);
    byteenable <= 4'hf;
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h12ab);
    foreach (rows[k]) begin
      bus(1'b1, OFS_CTRL, 32'h0, q);
      bus(1'b1, OFS_MODE, rows[k].mode, q);
      bus(1'b1, OFS_COUNT, {16'h0, rows[k].load}, q);
      bus(1'b1, OFS_CTRL, rows[k].ctrl, q);
      base = irqs;
      wbase = wraps;
      repeat (rows[k].n) pulse(rows[k].sel);
      bus(1'b0, OFS_COUNT, 32'h0, q);
      check(q, {16'h0, rows[k].cnt});
      check(32'(irqs - base), 32'(rows[k].irq));
      check(32'(wraps - wbase), 32'(rows[k].irq));
    end
    // Running write reaches only the reload value
    bus(1'b1, OFS_CTRL, 32'h0, q);
    bus(1'b1, OFS_MODE, 32'h10, q);
    bus(1'b1, OFS_COUNT, 32'h5, q);
    settle();
    check(pins, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1, q);
    bus(1'b1, OFS_COUNT, 32'h9, q);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h5);
    repeat (6) pulse(0);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h9);
    settle();
    check(pins, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0, q);
    settle();
    check(pins, 32'h0);
    bus(1'b1, OFS_MODE, 32'h30, q);
    settle();
    check(pins, 32'h1);
    // One-shot with a retrigger in mid-count
    bus(1'b1, OFS_MODE, 32'h13, q);
    bus(1'b1, OFS_COUNT, 32'h3, q);
    bus(1'b1, OFS_CTRL, 32'h1, q);
    settle();
    check(pins, 32'h0);
    base = irqs;
    bus(1'b1, OFS_CTRL, 32'h3, q);
    settle();
    check(pins, 32'h1);
    pulse(0);
    bus(1'b1, OFS_CTRL, 32'h3, q);
    repeat (2) pulse(0);
    settle();
    check(pins, 32'h1);
    pulse(0);
    settle();
    check(pins, 32'h0);
    check(32'(irqs - base), 32'h1);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h3);
    bus(1'b1, OFS_COUNT, 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'h3, q);
    settle();
    bus(1'b0, OFS_STAT, 32'h0, q);
    check(q & 32'h1, 32'h0);
    // Two-phase normal processing, then multiply-by-4 with Z clearing
    bus(1'b1, OFS_CTRL, 32'h0, q);
    bus(1'b1, OFS_MODE, 32'h181, q);
    bus(1'b1, OFS_COUNT, 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'h1, q);
    repeat (4) encoder_model_i.step(1'b1);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h1);
    check(pins & 32'h2, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h0, q);
    bus(1'b1, OFS_MODE, 32'h381, q);
    bus(1'b1, OFS_COUNT, 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'hd, q);
    repeat (4) encoder_model_i.step(1'b1);
    repeat (2) encoder_model_i.step(1'b0);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h2);
    encoder_model_i.zpulse();
    encoder_model_i.step(1'b1);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h0);
    encoder_model_i.step(1'b1);
    bus(1'b0, OFS_COUNT, 32'h0, q);
    check(q, 32'h1);
    results();
  end
endmodule
